// ### src/eti_cfg.svh
// Offsets, field positions, reset values and timing counts of the irq unit
`ifndef ETI_CFG_SVH
`define ETI_CFG_SVH

// Register indices; byte address is four times the index
`define ETI_IDX_CENTRAL   8'he6
`define ETI_IDX_EDGE      8'hf2
`define ETI_IDX_PEND      8'hf3
`define ETI_IDX_MASK      8'hf4
`define ETI_IDX_PRIO      8'hf5
`define ETI_IDX_VSEL      8'hf6
`define ETI_IDX_NEST      8'hf7
`define ETI_IDX_SRCSEL    8'hf9

// Reset values
`define ETI_RST_CENTRAL   8'h87
`define ETI_RST_EDGE      8'h00
`define ETI_RST_PEND      8'h00
`define ETI_RST_MASK      8'h00
`define ETI_RST_PRIO      8'hff
`define ETI_RST_VSEL      8'h06
`define ETI_RST_NEST      8'h00
`define ETI_RST_SRCSEL    8'h01

// Central control fields
`define ETI_CEN_MFT       7
`define ETI_CEN_TOPPEND   6
`define ETI_CEN_TOPMASK   5
`define ETI_CEN_GIE       4
`define ETI_CEN_NESTED    3
// Vector and select fields
`define ETI_VSEL_TOPEDGE  3
`define ETI_VSEL_TOPSRC   2
`define ETI_VSEL_ASRC     1
`define ETI_VSEL_EWEN     0
`define ETI_NEST_LOCK     7
// Own source select fields
`define ETI_SRC_C_SEL     0
`define ETI_SRC_D_SEL     1

// Arbitration sample period in core clocks
`define ETI_ARB_PERIOD    3'd5
`define ETI_LVL_NONE      3'h7
// Interrupt entry cycle figures in core clocks
`define ETI_ENTRY_BASE    5'd18
`define ETI_ENTRY_STACK   5'd2
`define ETI_ENTRY_CSR     5'd2
`define ETI_ENTRY_WAKE    5'd1
// Response window figures, user event to routine start
`define ETI_RESP_EXT_MIN  26
`define ETI_RESP_EXT_DIV  55
`define ETI_RESP_EXT_MUL  53
`define ETI_RESP_EXT_OTH  49
`define ETI_RESP_TOP_MIN  22
`define ETI_RESP_TOP_DIV  51
`define ETI_RESP_TOP_MUL  49
`define ETI_RESP_TOP_OTH  45

`endif

// ### src/eti_pkg.sv
// Types shared by the irq unit modules
package eti_pkg;
   typedef logic [2:0] eti_level_t;
   typedef logic [2:0] eti_chan_t;
   typedef enum logic [0:0] {TOP_IDLE, TOP_SERVICE} eti_top_state_t;
endpackage

// ### src/eti_evt_if.sv
// Source selects and trigger events between control and detector
`timescale 1ns/1ps
`default_nettype none
interface eti_evt_if;
   logic [7:0] edge_sel;
   logic       a_src_sel;
   logic       c_src_sel;
   logic       d_src_sel;
   logic       spi_pins_free;
   logic       top_src_sel;
   logic       top_edge_sel;
   logic       wdog_eoc;
   logic       spi_irq;
   logic       stmr_irq;
   logic       ccu_irq;
   logic [7:0] chan_evt;
   logic       top_evt;
   modport ctl (output edge_sel, a_src_sel, c_src_sel, d_src_sel,
                spi_pins_free, top_src_sel, top_edge_sel, wdog_eoc,
                spi_irq, stmr_irq, ccu_irq, input chan_evt, top_evt);
   modport det (input edge_sel, a_src_sel, c_src_sel, d_src_sel,
                spi_pins_free, top_src_sel, top_edge_sel, wdog_eoc,
                spi_irq, stmr_irq, ccu_irq, output chan_evt, top_evt);
endinterface
`default_nettype wire

// ### src/eti_edge_det.sv
// Pin synchronisers, source multiplexers and edge detectors
`timescale 1ns/1ps
`default_nettype none
module eti_edge_det (
   input  wire logic  hclk,
   input  wire logic  hresetn,
   input  wire logic [7:0] ext_pin,
   input  wire logic  nmi_pin,
   eti_evt_if.det     ev
);
   logic [8:0] sync1;
   logic [8:0] sync2;
   logic [8:0] prev;
   logic [8:0] next_sync1;
   logic [8:0] next_sync2;
   logic [8:0] next_prev;
   logic [8:0] src;

   // Pick each channel's source after the pins are synchronised
   always_comb
   begin
      src = sync2;
      src[0] = ev.a_src_sel ? sync2[0] : ev.wdog_eoc;
      src[2] = ev.spi_pins_free ? sync2[2] : ev.spi_irq;
      src[4] = ev.c_src_sel ? sync2[4] : ev.stmr_irq;
      src[6] = ev.d_src_sel ? ev.ccu_irq : sync2[6];
      src[8] = ev.top_src_sel ? sync2[8] : ev.wdog_eoc;
      next_sync1 = {nmi_pin, ext_pin};
      next_sync2 = sync1;
      next_prev = src;
   end

   // Only the second stage is looked at; input must hold a cycle
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         sync1 <= 9'h000;
         sync2 <= 9'h000;
         prev  <= 9'h000;
      end
      else
      begin
         sync1 <= next_sync1;
         sync2 <= next_sync2;
         prev  <= next_prev;
      end
   end

   // Switching a select can itself look like an edge
   genvar g;
   generate
      for (g = 0; g < 8; g++)
      begin : g_chan
         assign ev.chan_evt[g] = ev.edge_sel[g] ? (src[g] & ~prev[g])
                                                : (~src[g] & prev[g]);
      end
   endgenerate

   // Watchdog end of count is taken on its rising edge only
   assign ev.top_evt = (ev.top_src_sel && !ev.top_edge_sel) ?
                       (~src[8] & prev[8]) : (src[8] & ~prev[8]);

   a_top_pin_rise: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (ev.top_src_sel && ev.top_edge_sel && sync2[8] && !prev[8])
      |-> ev.top_evt)
      else $error("top rising edge not flagged");
endmodule
`default_nettype wire

// ### src/eti_irq_top.sv
// External and top-level interrupt front end with AHB-Lite registers
//
// Functional notes
// - Eight external channels in four pairs
// - Edge bit picks rising or falling; mask each
// - Two-bit pair code; even higher, odd lower
// - A0 source pin zero or watchdog
// - B0 pin two only when serial bits zero
// - C0 source pin four or standard timer
// - D0 source pin six or clock unit
// - Top source pin or watchdog end count
// - Top edge bit picks pin rising or falling; watchdog rising
// - Top event sets top pending flag
// - Maskable top needs mask, enable, pending
// - Lock bit set-only; pending then ignores enable
// - Nothing accepted while top routine runs
// - Top leaves enable, level, hold bits untouched
// - Pending set by hardware, software sets/clears
// - Request needs mask, pending and enable
// - Three-bit level, seven never taken; vector
// - Sample every five clocks; ack one extra
// - Abort instruction unless a write happened
// - Entry 18 clocks plus stack, segment, wake
// - Response windows for external and top
// - Acknowledge clears external pending flag
// - Level low bit fixed by channel parity
// - Top ack clears pending; software may set
`timescale 1ns/1ps
`default_nettype none
`include "eti_cfg.svh"
module eti_irq_top (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic [7:0]  ext_pin,
   input  wire logic        nmi_pin,
   input  wire logic        wdog_eoc,
   input  wire logic        spi_irq,
   input  wire logic        serial_periph_enable,
   input  wire logic        serial_mode_select,
   input  wire logic        stmr_irq,
   input  wire logic        ccu_irq,
   input  wire logic        ext_ack,
   input  wire logic        ext_iret,
   input  wire logic        top_ack,
   input  wire logic        top_iret,
   input  wire logic        instr_written,
   input  wire logic        stack_in_regfile,
   input  wire logic        save_code_segment_enable,
   input  wire logic        wfi_mode,
   output logic             ext_req,
   output logic [2:0]       ext_level,
   output logic [7:0]       ext_vector,
   output logic             top_req,
   output logic             abort_instr,
   output logic             dma_hold,
   output logic [4:0]       entry_cycles,
   output logic             mft_enable,
   output logic             ext_wait_enable
);
   eti_evt_if ev ();

   // Control state
   logic                      top_pend, top_mask, gie, iam, lock;
   logic                      top_edge_sel, top_src_sel, a_src_sel;
   logic                      c_src_sel, d_src_sel;
   eti_pkg::eti_level_t       clvl;
   logic [7:0]                edge_sel, ext_pend, ext_mask, pair_prio;
   logic [3:0]                v_hi;
   logic [6:0]                hold;
   logic [2:0]                arb_cnt;
   eti_pkg::eti_chan_t        ext_chan;
   logic                      ack_d, top_ack_d, wr_pend;
   logic [7:0]                wr_idx;
   eti_pkg::eti_top_state_t   top_state;
   // Next values
   logic                      next_top_pend, next_top_mask, next_gie;
   logic                      next_iam, next_lock, next_gcen, next_ewen;
   logic                      next_top_edge_sel, next_top_src_sel;
   logic                      next_a_src_sel, next_c_src_sel;
   logic                      next_d_src_sel;
   eti_pkg::eti_level_t       next_clvl, next_ext_level;
   logic [7:0]                next_edge_sel, next_ext_pend, next_ext_mask;
   logic [7:0]                next_pair_prio, next_ext_vector, next_wr_idx;
   logic [3:0]                next_v_hi;
   logic [6:0]                next_hold;
   logic [2:0]                next_arb_cnt;
   eti_pkg::eti_chan_t        next_ext_chan;
   logic                      next_ack_d, next_top_ack_d, next_wr_pend;
   logic                      next_ext_req, next_top_req, next_abort;
   logic [31:0]               next_hrdata;
   logic [4:0]                next_entry;
   eti_pkg::eti_top_state_t   next_top_state;
   // Helpers
   logic                      take, addr_ok, sample, top_cand, win_ok;
   logic [7:0]                wd, rd_val;
   logic [3:0]                popped;
   eti_pkg::eti_level_t       win_lvl, lvl;
   eti_pkg::eti_chan_t        win_chan;

   // Even channel gets the even level, odd channel the next one
   function automatic eti_pkg::eti_level_t chan_level(
      input logic [7:0] pp,
      input logic [2:0] ch);
      chan_level = {pp[{ch[2:1], 1'b1}], pp[{ch[2:1], 1'b0}], ch[0]};
   endfunction

   // Most recent suspended level is the lowest set hold bit
   function automatic logic [3:0] hold_pop(input logic [6:0] h);
      hold_pop = {1'b0, `ETI_LVL_NONE};
      for (int k = 6; k >= 0; k--)
      begin
         if (h[k])
         begin
            hold_pop = {1'b1, 3'(k)};
         end
      end
   endfunction

   // Configuration handed to the detector
   assign ev.edge_sel      = edge_sel;
   assign ev.a_src_sel     = a_src_sel;
   assign ev.c_src_sel     = c_src_sel;
   assign ev.d_src_sel     = d_src_sel;
   assign ev.spi_pins_free = !serial_periph_enable && !serial_mode_select;
   assign ev.top_src_sel   = top_src_sel;
   assign ev.top_edge_sel  = top_edge_sel;
   assign ev.wdog_eoc      = wdog_eoc;
   assign ev.spi_irq       = spi_irq;
   assign ev.stmr_irq      = stmr_irq;
   assign ev.ccu_irq       = ccu_irq;

   eti_edge_det u_det (
      .hclk    (hclk),
      .hresetn (hresetn),
      .ext_pin (ext_pin),
      .nmi_pin (nmi_pin),
      .ev      (ev)
   );

   // Bus decode and read mux
   always_comb
   begin
      take = hsel && hready && htrans[1];
      addr_ok = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0);
      wd = hwdata[7:0];
      unique case (haddr[9:2])
         `ETI_IDX_CENTRAL: rd_val = {mft_enable, top_pend, top_mask, gie,
                                     iam, clvl};
         `ETI_IDX_EDGE:   rd_val = edge_sel;
         `ETI_IDX_PEND:   rd_val = ext_pend;
         `ETI_IDX_MASK:   rd_val = ext_mask;
         `ETI_IDX_PRIO:   rd_val = pair_prio;
         `ETI_IDX_VSEL:   rd_val = {v_hi, top_edge_sel, top_src_sel,
                                    a_src_sel, ext_wait_enable};
         `ETI_IDX_NEST:   rd_val = {lock, hold};
         `ETI_IDX_SRCSEL: rd_val = {6'h00, d_src_sel, c_src_sel};
         default:         rd_val = 8'h00;
      endcase
      next_hrdata = (take && !hwrite && addr_ok) ? {24'h000000, rd_val}
                                                 : 32'h00000000;
      next_wr_pend = take && hwrite && addr_ok && (hsize == 3'h2);
      next_wr_idx = haddr[9:2];
   end

   // Winner among external channels; lower code wins, ties to lower index
   always_comb
   begin
      win_ok = 1'b0;
      win_lvl = `ETI_LVL_NONE;
      win_chan = 3'h0;
      lvl = 3'h0;
      for (int i = 7; i >= 0; i--)
      begin
         lvl = chan_level(pair_prio, 3'(i));
         if (ext_pend[i] && ext_mask[i] && gie && (lvl < clvl) &&
             (lvl != `ETI_LVL_NONE) && (lvl <= win_lvl))
         begin
            win_ok = 1'b1;
            win_lvl = lvl;
            win_chan = 3'(i);
         end
      end
   end

   // Next values of the control registers, pending flags and nesting state
   always_comb
   begin
      popped = hold_pop(hold);
      next_gcen = mft_enable;
      next_top_pend = top_pend;
      next_top_mask = top_mask;
      next_gie = gie;
      next_iam = iam;
      next_clvl = clvl;
      next_edge_sel = edge_sel;
      next_ext_pend = ext_pend;
      next_ext_mask = ext_mask;
      next_pair_prio = pair_prio;
      next_v_hi = v_hi;
      next_top_edge_sel = top_edge_sel;
      next_top_src_sel = top_src_sel;
      next_a_src_sel = a_src_sel;
      next_ewen = ext_wait_enable;
      next_lock = lock;
      next_hold = hold;
      next_c_src_sel = c_src_sel;
      next_d_src_sel = d_src_sel;
      // Software writes land in the data phase
      if (wr_pend)
      begin
         unique case (wr_idx)
            `ETI_IDX_CENTRAL:
            begin
               next_gcen = wd[`ETI_CEN_MFT];
               next_top_pend = wd[`ETI_CEN_TOPPEND];
               next_top_mask = wd[`ETI_CEN_TOPMASK];
               next_gie = wd[`ETI_CEN_GIE];
               next_iam = wd[`ETI_CEN_NESTED];
               next_clvl = wd[2:0];
            end
            `ETI_IDX_EDGE: next_edge_sel = wd;
            `ETI_IDX_PEND: next_ext_pend = wd;
            `ETI_IDX_MASK: next_ext_mask = wd;
            `ETI_IDX_PRIO: next_pair_prio = wd;
            `ETI_IDX_VSEL:
            begin
               next_v_hi = wd[7:4];
               next_top_edge_sel = wd[`ETI_VSEL_TOPEDGE];
               next_top_src_sel = wd[`ETI_VSEL_TOPSRC];
               next_a_src_sel = wd[`ETI_VSEL_ASRC];
               next_ewen = wd[`ETI_VSEL_EWEN];
            end
            `ETI_IDX_NEST:
            begin
               next_lock = lock | wd[`ETI_NEST_LOCK];
               next_hold = wd[6:0];
            end
            `ETI_IDX_SRCSEL:
            begin
               next_c_src_sel = wd[`ETI_SRC_C_SEL];
               next_d_src_sel = wd[`ETI_SRC_D_SEL];
            end
            default: next_gcen = mft_enable;
         endcase
      end
      // Machine cycle effects one clock after the acknowledge
      if (ack_d)
      begin
         next_ext_pend[ext_chan] = 1'b0;
         next_gie = 1'b0;
         if (iam)
         begin
            if (clvl != `ETI_LVL_NONE)
            begin
               next_hold[clvl] = 1'b1;
            end
            next_clvl = ext_level;
         end
      end
      if (ext_iret)
      begin
         next_gie = 1'b1;
         if (iam)
         begin
            next_clvl = popped[2:0];
            if (popped[3])
            begin
               next_hold[popped[2:0]] = 1'b0;
            end
         end
      end
      // Top ack clears only its own pending flag
      if (top_ack_d)
      begin
         next_top_pend = 1'b0;
      end
      // Hardware sets win over any clear in the same cycle
      next_ext_pend = next_ext_pend | ev.chan_evt;
      next_top_pend = next_top_pend | ev.top_evt;
   end

   // Arbitration timing, request outputs and top service state
   always_comb
   begin
      sample = (arb_cnt == `ETI_ARB_PERIOD - 3'd1);
      next_arb_cnt = sample ? 3'd0 : arb_cnt + 3'd1;
      top_cand = top_pend && (lock || (top_mask && gie)) &&
                 (top_state == eti_pkg::TOP_IDLE);
      next_top_state = top_state;
      unique case (top_state)
         eti_pkg::TOP_IDLE:
            if (top_ack && top_req)
            begin
               next_top_state = eti_pkg::TOP_SERVICE;
            end
         eti_pkg::TOP_SERVICE:
            if (top_iret)
            begin
               next_top_state = eti_pkg::TOP_IDLE;
            end
      endcase
      next_top_req = sample ? top_cand : top_req;
      next_ext_req = ext_req;
      next_ext_level = ext_level;
      next_ext_vector = ext_vector;
      next_ext_chan = ext_chan;
      if (sample && !ack_d)
      begin
         next_ext_req = win_ok && !top_cand;
         next_ext_level = win_lvl;
         next_ext_chan = win_chan;
         next_ext_vector = {v_hi, win_chan, 1'b0};
      end
      if (top_ack || next_top_state == eti_pkg::TOP_SERVICE)
      begin
         next_top_req = 1'b0;
         next_ext_req = 1'b0;
      end
      if (ext_ack)
      begin
         next_ext_req = 1'b0;
      end
      next_ack_d = ext_ack && ext_req;
      next_top_ack_d = top_ack && top_req;
      next_abort = (next_ext_req || next_top_req) && !instr_written;
      next_entry = `ETI_ENTRY_BASE
                 + (stack_in_regfile ? `ETI_ENTRY_STACK : 5'd0)
                 + (save_code_segment_enable ? `ETI_ENTRY_CSR : 5'd0)
                 + (wfi_mode ? `ETI_ENTRY_WAKE : 5'd0);
   end

   // All state registered here
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         {mft_enable, top_pend, top_mask, gie, iam, clvl}
            <= `ETI_RST_CENTRAL;
         edge_sel <= `ETI_RST_EDGE;
         ext_pend <= `ETI_RST_PEND;
         ext_mask <= `ETI_RST_MASK;
         pair_prio <= `ETI_RST_PRIO;
         {v_hi, top_edge_sel, top_src_sel, a_src_sel, ext_wait_enable}
            <= `ETI_RST_VSEL;
         {lock, hold} <= `ETI_RST_NEST;
         {d_src_sel, c_src_sel} <= 2'(`ETI_RST_SRCSEL);
         arb_cnt <= 3'd0;
         ext_chan <= 3'h0;
         ack_d <= 1'b0;
         top_ack_d <= 1'b0;
         wr_pend <= 1'b0;
         wr_idx <= 8'h00;
         top_state <= eti_pkg::TOP_IDLE;
         hrdata <= 32'h00000000;
         hreadyout <= 1'b0;
         hresp <= 1'b0;
         ext_req <= 1'b0;
         ext_level <= `ETI_LVL_NONE;
         ext_vector <= 8'h00;
         top_req <= 1'b0;
         abort_instr <= 1'b0;
         dma_hold <= 1'b0;
         entry_cycles <= `ETI_ENTRY_BASE;
      end
      else
      begin
         {mft_enable, top_pend, top_mask, gie, iam, clvl}
            <= {next_gcen, next_top_pend, next_top_mask, next_gie,
                next_iam, next_clvl};
         edge_sel <= next_edge_sel;
         ext_pend <= next_ext_pend;
         ext_mask <= next_ext_mask;
         pair_prio <= next_pair_prio;
         {v_hi, top_edge_sel, top_src_sel, a_src_sel, ext_wait_enable}
            <= {next_v_hi, next_top_edge_sel, next_top_src_sel,
                next_a_src_sel, next_ewen};
         {lock, hold} <= {next_lock, next_hold};
         {c_src_sel, d_src_sel} <= {next_c_src_sel, next_d_src_sel};
         arb_cnt <= next_arb_cnt;
         ext_chan <= next_ext_chan;
         ack_d <= next_ack_d;
         top_ack_d <= next_top_ack_d;
         wr_pend <= next_wr_pend;
         wr_idx <= next_wr_idx;
         top_state <= next_top_state;
         hrdata <= next_hrdata;
         hreadyout <= 1'b1; // Zero wait states
         hresp <= 1'b0;
         ext_req <= next_ext_req;
         ext_level <= next_ext_level;
         ext_vector <= next_ext_vector;
         top_req <= next_top_req;
         abort_instr <= next_abort;
         dma_hold <= (next_top_state == eti_pkg::TOP_SERVICE);
         entry_cycles <= next_entry;
      end
   end

   a_lock_sticky: assert property (
      @(posedge hclk) disable iff (!hresetn)
      $past(lock) |-> lock)
      else $error("lock bit cleared without reset");

   a_top_blocks_ext: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (top_state == eti_pkg::TOP_SERVICE) |-> (!ext_req && !top_req && dma_hold))
      else $error("request accepted during top routine");

   a_sample_period: assert property (
      @(posedge hclk) disable iff (!hresetn)
      $rose(ext_req) |-> ($past(arb_cnt) == 3'd4))
      else $error("request raised off the sample point");

   a_req_needs_gie: assert property (
      @(posedge hclk) disable iff (!hresetn)
      $rose(ext_req) |-> ($past(gie) &&
         (|($past(ext_pend) & $past(ext_mask) & (8'h01 << ext_chan)))))
      else $error("request without enable, pending or mask");

   a_level_seven: assert property (
      @(posedge hclk) disable iff (!hresetn)
      ext_req |-> (ext_level != 3'h7 && ext_level[0] == ext_chan[0]))
      else $error("bad level on request");

   a_top_keeps_state: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (top_ack_d && !wr_pend && !ext_iret && !ack_d)
      |=> ($stable(gie) && $stable(clvl) && $stable(hold)))
      else $error("top entry changed enable or level");

   a_ack_clears: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (ack_d && !ev.chan_evt[ext_chan]) |=> !ext_pend[$past(ext_chan)])
      else $error("pending not cleared on acknowledge");

   a_abort_gate: assert property (
      @(posedge hclk) disable iff (!hresetn)
      abort_instr |-> ((ext_req || top_req) && !$past(instr_written)))
      else $error("abort despite completed write");

   a_top_event: assert property (
      @(posedge hclk) disable iff (!hresetn)
      ev.top_evt |=> top_pend)
      else $error("top event lost");
endmodule
`default_nettype wire

// ### bench/eti_core_model.sv
// Core sequencer model that accepts each raised request once
`timescale 1ns/1ps
`default_nettype none
module eti_core_model (
   input  wire logic hclk,
   input  wire logic ext_req,
   input  wire logic top_req,
   output var logic  ext_ack = 1'h0,
   output var logic  top_ack = 1'h0
);
   // One-cycle ack; skips a cycle so a stale level is not taken twice
   always @(posedge hclk)
   begin
      ext_ack <= ext_req & ~ext_ack;
      top_ack <= top_req & ~top_ack;
   end
endmodule
`default_nettype wire

// ### bench/ext_and_top_level_irq_unit_tb.sv
// Self-checking bench for the external and top-level irq front end
`timescale 1ns/1ps
`default_nettype none
`include "eti_cfg.svh"
module ext_and_top_level_irq_unit_tb;
   logic        hclk = 1'h0;
   logic        hresetn = 1'h0;
   logic        hsel = 1'h0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic [7:0]  ext_pin = 8'h0;
   logic        nmi_pin = 1'h0;
   logic        per = 1'h0;
   logic        stk = 1'h0;
   logic        tiret = 1'h0;
   logic        ext_req, top_req, ext_ack, top_ack, dma_hold, resp, ab;
   logic [7:0]  vec;
   logic [2:0]  lvl;
   logic [4:0]  ecyc;
   logic [31:0] rd;
   int          errors = 0;
   int          n_tests = 0;
   int          n;
   logic [7:0]  ri [8] = '{`ETI_IDX_CENTRAL, `ETI_IDX_EDGE, `ETI_IDX_PEND,
      `ETI_IDX_MASK, `ETI_IDX_PRIO, `ETI_IDX_VSEL, `ETI_IDX_NEST,
      `ETI_IDX_SRCSEL};
   logic [7:0]  rv [8] = '{8'h87, 8'h00, 8'h00, 8'h00, 8'hff, 8'h06,
      8'h00, 8'h01};

   // Period of 10 ns
   always #5 hclk = ~hclk;

   eti_irq_top u_dut (
      .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
      .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp(resp),
      .ext_pin, .nmi_pin, .wdog_eoc(per), .spi_irq(per), .stmr_irq(per),
      .ccu_irq(per), .serial_periph_enable(1'h0),
      .serial_mode_select(1'h0), .ext_ack, .ext_iret(tiret), .top_ack,
      .top_iret(tiret), .instr_written(1'h0), .stack_in_regfile(stk),
      .save_code_segment_enable(stk), .wfi_mode(stk), .ext_req,
      .ext_level(lvl), .ext_vector(vec), .top_req, .abort_instr(ab),
      .dma_hold, .entry_cycles(ecyc), .mft_enable(), .ext_wait_enable()
   );

   eti_core_model u_core (.hclk, .ext_req, .top_req, .ext_ack, .top_ack);

   task automatic print_verdict;
      if (errors == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] got,
                      input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         errors++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // Bounded wait for hready; a hang ends the run as a mismatch
   task automatic rdy;
      for (n = 0; n == 0 || (hreadyout !== 1'h1 && n < 50); n++)
         @(posedge hclk);
      if (n >= 50)
      begin
         errors++;
         print_verdict();
      end
   endtask

   // Single word transfer: address phase, then data phase
   task automatic bus(input logic w, input logic [7:0] idx,
                      input logic [7:0] wd);
      hsel   <= 1'h1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr  <= {22'h0, idx, 2'h0};
      rdy();
      htrans <= 2'h0;
      hsel   <= 1'h0;
      hwdata <= {24'h0, wd};
      rdy();
      rd = hrdata;
   endtask

   task automatic rchk(input string nm, input logic [7:0] idx,
                       input logic [7:0] exp);
      bus(1'h0, idx, 8'h00);
      chk(nm, rd, {24'h0, exp});
   endtask

   // Bounded wait for a request line, sampled at the edge
   task automatic req_wait(input logic top);
      for (n = 0; n < 60 && (top ? top_req : ext_req) !== 1'h1; n++)
         @(posedge hclk);
      if (n >= 60)
      begin
         errors++;
         print_verdict();
      end
   endtask

   // Main sequence; pin levels are held many cycles each
   initial
   begin
      repeat (6) @(posedge hclk);
      hresetn <= 1'h1;
      for (int i = 0; i < 8; i++)
         rchk("reset value", ri[i], rv[i]);
      rchk("unmapped", 8'hf8, 8'h00);
      chk("okay resp", resp, 1'h0);
      chk("entry base", ecyc, 5'h12);
      bus(1'h1, `ETI_IDX_EDGE, 8'h01);
      bus(1'h1, `ETI_IDX_MASK, 8'h01);
      bus(1'h1, `ETI_IDX_PRIO, 8'hfd);
      bus(1'h1, `ETI_IDX_CENTRAL, 8'h97);
      ext_pin <= 8'h03;
      req_wait(1'h0);
      chk("ext level", lvl, 3'h2);
      chk("ext vector", vec, 8'h00);
      chk("abort", ab, 1'h1);
      repeat (4) @(posedge hclk);
      rchk("ack clears", `ETI_IDX_PEND, 8'h00);
      ext_pin <= 8'h00;
      repeat (6) @(posedge hclk);
      rchk("falling edge", `ETI_IDX_PEND, 8'h02);
      bus(1'h1, `ETI_IDX_PEND, 8'h00);
      rchk("soft clear", `ETI_IDX_PEND, 8'h00);
      bus(1'h1, `ETI_IDX_NEST, 8'h80);
      bus(1'h1, `ETI_IDX_NEST, 8'h00);
      rchk("lock set only", `ETI_IDX_NEST, 8'h80);
      bus(1'h1, `ETI_IDX_VSEL, 8'h0e);
      nmi_pin <= 1'h1;
      req_wait(1'h1);
      repeat (3) @(posedge hclk);
      chk("dma hold", dma_hold, 1'h1);
      rchk("top ack", `ETI_IDX_CENTRAL, 8'h87);
      bus(1'h1, `ETI_IDX_CENTRAL, 8'hc7);
      repeat (10) @(posedge hclk);
      chk("top in routine", top_req, 1'h0);
      tiret <= 1'h1;
      @(posedge hclk);
      tiret <= 1'h0;
      req_wait(1'h1);
      stk <= 1'h1;
      repeat (3) @(posedge hclk);
      chk("entry full", ecyc, 5'h17);
      print_verdict();
   end
endmodule
`default_nettype wire
